// ==== verilog/mbal_pkg.sv ====
// Constants, encodings and carrier structs shared by the access-log and exception block.
// ----------------------------------------------------------------------------
// How it works
// - Access-log query returns logged start and count.
// - Only read and multi-write queries fill log.
// - Other functions log zero address and count.
// - Access-log query to address zero is invalid.
// - Log reply: address, function, start, count, CRC.
// - Address fields hold register number minus base.
// - Bad function, address or data gets error.
// - Comm errors get no response at all.
// - Broadcast queries never get error responses.
// - Error function byte is request plus 80h.
// - Error reply echoes received slave address.
// - Error frame: address, function, code, CRC.
// - Unhandled function returns exception code 01.
// - Unhandled register address returns code 02.
// - Unhandled data returns exception code 03.
// - Read with one readable register: no address error.
// - Write with one writable register: no address error.
// - Skip missing or disabled registers silently.
// - Address error only when no register exists.
// - Frames under four bytes get no response.
// ----------------------------------------------------------------------------
package mbal_pkg;

    // ------------------------------------------------------------------------
    // Function and exception codes
    // ------------------------------------------------------------------------
    localparam logic [7:0]  FN_READ_HOLD   = 8'h03;
    localparam logic [7:0]  FN_WRITE_MULTI = 8'h10;
    localparam logic [7:0]  FN_ACCESS_LOG  = 8'h46;
    localparam logic [7:0]  FN_ERR_FLAG    = 8'h80;
    localparam logic [7:0]  EXC_NONE       = 8'h00;
    localparam logic [7:0]  EXC_FUNCTION   = 8'h01;
    localparam logic [7:0]  EXC_ADDRESS    = 8'h02;
    localparam logic [7:0]  EXC_DATA       = 8'h03;
    localparam logic [7:0]  BCAST_ADDR     = 8'h00;

    // ------------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------------
    localparam int          HDR_BYTES      = 6;
    localparam logic [7:0]  HDR_ADDR_POS   = 8'h00;
    localparam logic [7:0]  HDR_FUNC_POS   = 8'h01;
    localparam logic [7:0]  HDR_STH_POS    = 8'h02;
    localparam logic [7:0]  HDR_STL_POS    = 8'h03;
    localparam logic [7:0]  HDR_CNH_POS    = 8'h04;
    localparam logic [7:0]  HDR_CNL_POS    = 8'h05;
    localparam logic [7:0]  MIN_FRAME_LEN  = 8'h04;
    localparam logic [7:0]  MAX_FRAME_LEN  = 8'hFF;
    localparam int          RESP_BYTES     = 6;
    localparam logic [2:0]  LOG_PAY_LEN    = 3'h6;
    localparam logic [2:0]  ERR_PAY_LEN    = 3'h3;

    // ------------------------------------------------------------------------
    // CRC constants
    // ------------------------------------------------------------------------
    localparam logic [15:0] CRC_POLY       = 16'hA001;
    localparam logic [15:0] CRC_INIT       = 16'hFFFF;
    localparam logic [15:0] CRC_RESIDUE    = 16'h0000;

    // ------------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------------
    localparam logic [15:0] LOG_RESET      = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] start;
        logic [15:0] count;
        logic        bcast;
    } mbal_svc_req_s;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] ok_count;
        logic [15:0] first_ok;
    } mbal_svc_rsp_s;

    typedef struct packed {
        logic [15:0] start;
        logic [15:0] count;
    } mbal_log_s;

endpackage

// ==== verilog/mbal_crc16.sv ====
// Byte-wide CRC-16 accumulator for field-bus frames.
`timescale 1ns/10ps
module mbal_crc16
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        clr_i,
    input  wire logic        vld_i,
    input  wire logic [7:0]  byte_i,
    output logic      [15:0] crc_o,
    output logic      [15:0] crc_nxt_o
);

    logic [15:0] crc_r;
    logic [15:0] stage [0:8];

    assign stage[0] = crc_r ^ {8'h00, byte_i};

    // One shift-and-fold step per data bit, least significant bit first.
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_bit
            assign stage[b+1] = stage[b][0] ? ((stage[b] >> 1) ^ mbal_pkg::CRC_POLY)
                                            : (stage[b] >> 1);
        end
    endgenerate

    assign crc_nxt_o = stage[8];
    assign crc_o     = crc_r;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            crc_r <= mbal_pkg::CRC_INIT;
        else if (ce_i)
        begin
            if (clr_i)
                crc_r <= mbal_pkg::CRC_INIT;
            else if (vld_i)
                crc_r <= stage[8];
        end
    end

endmodule // mbal_crc16

// ==== verilog/mbal_top.sv ====
// Slave query handler: access log, error responses and silent drops.
`timescale 1ns/10ps
module mbal_top
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic [7:0]              own_addr_i,
    input  wire logic [7:0]              rx_data_i,
    input  wire logic                    rx_valid_i,
    input  wire logic                    rx_err_i,
    input  wire logic                    rx_end_i,
    output logic                         svc_req_o,
    output mbal_pkg::mbal_svc_req_s      svc_o,
    input  wire logic                    svc_done_i,
    input  wire mbal_pkg::mbal_svc_rsp_s svc_rsp_i,
    output logic                         norm_go_o,
    output mbal_pkg::mbal_log_s          log_o,
    output logic                         tx_valid_o,
    output logic [7:0]                   tx_data_o,
    output logic                         tx_last_o,
    input  wire logic                    tx_ready_i
);

    // ------------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RX,
        ST_SVC,
        ST_TX
    } mbal_state_e;

    mbal_state_e             state_r;
    mbal_state_e             state_nxt;
    logic [7:0]              hdr_r [0:mbal_pkg::HDR_BYTES-1];
    logic [7:0]              len_r;
    logic                    err_r;
    logic [7:0]              resp_r [0:mbal_pkg::RESP_BYTES-1];
    logic [2:0]              pay_len_r;
    logic [2:0]              idx_r;
    logic [1:0]              crc_phase_r;
    logic                    svc_req_r;
    mbal_pkg::mbal_svc_req_s svc_r;
    mbal_pkg::mbal_log_s     log_r;
    logic                    norm_go_r;
    logic                    tx_valid_r;
    logic [7:0]              tx_data_r;
    logic                    tx_last_r;

    // ------------------------------------------------------------------------
    // CRC, shared by receive and transmit since the link is half duplex
    // ------------------------------------------------------------------------
    logic        crc_clr;
    logic        crc_vld;
    logic [7:0]  crc_byte;
    logic [15:0] crc_cur;
    logic [15:0] crc_nxt;

    mbal_crc16 u_crc
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (crc_clr),
        .vld_i     (crc_vld),
        .byte_i    (crc_byte),
        .crc_o     (crc_cur),
        .crc_nxt_o (crc_nxt)
    );

    // ------------------------------------------------------------------------
    // Receive decode
    // ------------------------------------------------------------------------
    wire        rx_take    = (state_r == ST_RX) && rx_valid_i;
    wire        rx_close   = (state_r == ST_RX) && rx_end_i;
    wire        len_short  = len_r < mbal_pkg::MIN_FRAME_LEN;
    wire        crc_bad    = crc_cur != mbal_pkg::CRC_RESIDUE;
    wire        comm_bad   = err_r || crc_bad || len_short;
    wire [7:0]  q_addr     = hdr_r[mbal_pkg::HDR_ADDR_POS[2:0]];
    wire [7:0]  q_func     = hdr_r[mbal_pkg::HDR_FUNC_POS[2:0]];
    wire [15:0] q_start    = {hdr_r[mbal_pkg::HDR_STH_POS[2:0]], hdr_r[mbal_pkg::HDR_STL_POS[2:0]]};
    wire [15:0] q_count    = {hdr_r[mbal_pkg::HDR_CNH_POS[2:0]], hdr_r[mbal_pkg::HDR_CNL_POS[2:0]]};
    wire        is_bcast   = q_addr == mbal_pkg::BCAST_ADDR;
    wire        addr_hit   = (q_addr == own_addr_i) || is_bcast;
    wire        is_log_q   = q_func == mbal_pkg::FN_ACCESS_LOG;
    wire        frame_ok   = rx_close && !comm_bad && addr_hit;
    wire        log_query  = frame_ok && is_log_q && !is_bcast;
    wire        bcast_log  = frame_ok && is_log_q && is_bcast;
    wire        svc_start  = frame_ok && !is_log_q;
    wire        hdr_wr     = rx_take && (len_r < 8'(mbal_pkg::HDR_BYTES));
    wire        len_inc    = rx_take && (len_r != mbal_pkg::MAX_FRAME_LEN);

    // ------------------------------------------------------------------------
    // Service outcome
    // ------------------------------------------------------------------------
    wire        svc_end    = (state_r == ST_SVC) && svc_done_i;
    wire        multi_fn   = (svc_r.func == mbal_pkg::FN_READ_HOLD) ||
                             (svc_r.func == mbal_pkg::FN_WRITE_MULTI);
    // Skipped registers count as harmless as long as one register of the range was served.
    wire        some_ok    = (svc_r.count != 16'h0000) && (svc_rsp_i.ok_count != 16'h0000);
    wire        none_ok    = !some_ok;
    wire        data_bad   = svc_rsp_i.code == mbal_pkg::EXC_DATA;
    wire        func_bad   = svc_rsp_i.code == mbal_pkg::EXC_FUNCTION;
    wire [7:0]  multi_code = data_bad ? mbal_pkg::EXC_DATA
                           : (none_ok ? mbal_pkg::EXC_ADDRESS : mbal_pkg::EXC_NONE);
    wire [7:0]  svc_code   = multi_fn ? (func_bad ? mbal_pkg::EXC_FUNCTION : multi_code)
                                      : svc_rsp_i.code;
    wire        svc_fail   = svc_code != mbal_pkg::EXC_NONE;
    wire        send_err   = svc_end && svc_fail && !svc_r.bcast;
    wire        send_norm  = svc_end && !svc_fail && !svc_r.bcast;
    wire        log_fill   = svc_end && multi_fn && !svc_fail;

    // ------------------------------------------------------------------------
    // Transmit sequencing
    // ------------------------------------------------------------------------
    wire        tx_fire    = tx_valid_r && tx_ready_i;
    wire        tx_in_pay  = crc_phase_r == 2'd0;
    wire        tx_pay_end = tx_in_pay && (idx_r == (pay_len_r - 3'd1));
    wire [2:0]  idx_next   = idx_r + 3'd1;
    wire        tx_done    = tx_fire && tx_last_r;
    wire        resp_load  = log_query || send_err;

    assign crc_clr  = ((state_r == ST_RX) && (rx_close || (len_r == 8'h00 && !rx_take))) || resp_load;
    assign crc_vld  = rx_take || (tx_fire && tx_in_pay);
    assign crc_byte = (state_r == ST_TX) ? tx_data_r : rx_data_i;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RX:
            begin
                if (log_query)
                    state_nxt = ST_TX;
                else if (svc_start)
                    state_nxt = ST_SVC;
            end
            ST_SVC:
            begin
                if (send_err)
                    state_nxt = ST_TX;
                else if (svc_end)
                    state_nxt = ST_RX;
            end
            ST_TX:
            begin
                if (tx_done)
                    state_nxt = ST_RX;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            state_r <= ST_RX;
        else if (ce_i)
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------------------
    // Frame collection; frames that arrive while busy are dropped unanswered.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            len_r <= mbal_pkg::BYTE_RESET;
            err_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_close || state_r != ST_RX)
            begin
                len_r <= mbal_pkg::BYTE_RESET;
                err_r <= 1'b0;
            end
            else
            begin
                if (len_inc)
                    len_r <= len_r + 8'd1;
                if (rx_err_i)
                    err_r <= 1'b1;
            end
        end
    end

    genvar h;
    generate
        for (h = 0; h < mbal_pkg::HDR_BYTES; h++)
        begin : g_hdr
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    hdr_r[h] <= mbal_pkg::BYTE_RESET;
                else if (ce_i)
                begin
                    if (rx_close)
                        hdr_r[h] <= hdr_r[h];
                    else if (hdr_wr && (len_r == 8'(h)))
                        hdr_r[h] <= rx_data_i;
                    else if (rx_take && (len_r == 8'h00))
                        hdr_r[h] <= mbal_pkg::BYTE_RESET;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Service request towards the register engine
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            svc_req_r <= 1'b0;
            svc_r     <= '0;
        end
        else if (ce_i)
        begin
            svc_req_r <= svc_start;
            if (svc_start)
            begin
                svc_r.func  <= q_func;
                svc_r.start <= q_start;
                svc_r.count <= q_count;
                svc_r.bcast <= is_bcast;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Access log: a read of the log is itself a query of another kind, so it
    // leaves zeros behind for the next one.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            log_r.start <= mbal_pkg::LOG_RESET;
            log_r.count <= mbal_pkg::LOG_RESET;
        end
        else if (ce_i)
        begin
            if (log_fill)
            begin
                log_r.start <= svc_rsp_i.first_ok;
                log_r.count <= svc_rsp_i.ok_count;
            end
            else if (svc_end || log_query || bcast_log)
            begin
                log_r.start <= mbal_pkg::LOG_RESET;
                log_r.count <= mbal_pkg::LOG_RESET;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            norm_go_r <= 1'b0;
        else if (ce_i)
            norm_go_r <= send_norm;
    end

    // ------------------------------------------------------------------------
    // Response image
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < mbal_pkg::RESP_BYTES; i++)
                resp_r[i] <= mbal_pkg::BYTE_RESET;
            pay_len_r <= mbal_pkg::ERR_PAY_LEN;
        end
        else if (ce_i)
        begin
            if (log_query)
            begin
                resp_r[0] <= q_addr;
                resp_r[1] <= q_func;
                resp_r[2] <= log_r.start[15:8];
                resp_r[3] <= log_r.start[7:0];
                resp_r[4] <= log_r.count[15:8];
                resp_r[5] <= log_r.count[7:0];
                pay_len_r <= mbal_pkg::LOG_PAY_LEN;
            end
            else if (send_err)
            begin
                resp_r[0] <= q_addr;
                resp_r[1] <= svc_r.func + mbal_pkg::FN_ERR_FLAG;
                resp_r[2] <= svc_code;
                resp_r[3] <= mbal_pkg::BYTE_RESET;
                resp_r[4] <= mbal_pkg::BYTE_RESET;
                resp_r[5] <= mbal_pkg::BYTE_RESET;
                pay_len_r <= mbal_pkg::ERR_PAY_LEN;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Transmit stream: payload, then CRC low byte, then CRC high byte.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_valid_r  <= 1'b0;
            tx_data_r   <= mbal_pkg::BYTE_RESET;
            tx_last_r   <= 1'b0;
            idx_r       <= 3'd0;
            crc_phase_r <= 2'd0;
        end
        else if (ce_i)
        begin
            if (state_r != ST_TX)
            begin
                tx_valid_r  <= 1'b0;
                tx_last_r   <= 1'b0;
                idx_r       <= 3'd0;
                crc_phase_r <= 2'd0;
                if (state_nxt == ST_TX)
                    tx_valid_r <= 1'b1;
                tx_data_r <= (state_nxt == ST_TX) ? (log_query ? q_addr : q_addr) : mbal_pkg::BYTE_RESET;
            end
            else if (tx_fire)
            begin
                if (tx_last_r)
                begin
                    tx_valid_r <= 1'b0;
                    tx_last_r  <= 1'b0;
                end
                else if (tx_pay_end)
                begin
                    tx_data_r   <= crc_nxt[7:0];
                    crc_phase_r <= 2'd1;
                end
                else if (!tx_in_pay)
                begin
                    tx_data_r   <= crc_cur[15:8];
                    tx_last_r   <= 1'b1;
                    crc_phase_r <= 2'd2;
                end
                else
                begin
                    tx_data_r <= resp_r[idx_next];
                    idx_r     <= idx_next;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign svc_req_o  = svc_req_r;
    assign svc_o      = svc_r;
    assign norm_go_o  = norm_go_r;
    assign log_o      = log_r;
    assign tx_valid_o = tx_valid_r;
    assign tx_data_o  = tx_data_r;
    assign tx_last_o  = tx_last_r;

endmodule // mbal_top

// ==== tb/mbal_props.sv ====
// Port checker for the query handler.
`timescale 1ns/10ps
module mbal_props
(
    input wire logic                    sys_clk_i,
    input wire logic                    rst_i,
    input wire logic [7:0]              own_addr_i,
    input wire logic                    svc_req_o,
    input wire mbal_pkg::mbal_svc_req_s svc_o,
    input wire logic                    svc_done_i,
    input wire logic                    norm_go_o,
    input wire logic                    tx_valid_o,
    input wire logic [7:0]              tx_data_o,
    input wire logic                    tx_last_o,
    input wire logic                    tx_ready_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    AST_BCAST: assert property (svc_done_i && svc_o.bcast |=> !tx_valid_o && !norm_go_o)
        else $error("reply to broadcast");
    AST_ADDR: assert property ($rose(tx_valid_o) |-> tx_data_o == own_addr_i)
        else $error("reply address");
    AST_FUNC: assert property ($rose(tx_valid_o) && tx_ready_i |=> tx_data_o == 8'h46
        || tx_data_o == (svc_o.func | 8'h80)) else $error("reply function byte");
    AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte dropped");
    AST_LAST: assert property (tx_last_o |-> tx_valid_o) else $error("last alone");
    AST_END: assert property (tx_last_o && tx_ready_i |=> !tx_valid_o) else $error("overlong reply");
    AST_NOLOG: assert property (svc_req_o |-> svc_o.func != 8'h46) else $error("log sent out");
    AST_NORM: assert property (norm_go_o |-> !tx_valid_o && !svc_o.bcast) else $error("bad go");
    cover property (svc_req_o);
    cover property (norm_go_o);
    cover property (tx_last_o && tx_ready_i);
endmodule // mbal_props
bind mbal_top mbal_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .own_addr_i(own_addr_i),
    .svc_req_o(svc_req_o), .svc_o(svc_o), .svc_done_i(svc_done_i), .norm_go_o(norm_go_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));

// ==== tb/mbal_engine_model.sv ====
// Register engine stand-in answering each service request.
`timescale 1ns/10ps
module mbal_engine_model
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    req_i,
    input  wire mbal_pkg::mbal_svc_rsp_s rsp_i,
    output logic                         done_o,
    output mbal_pkg::mbal_svc_rsp_s      rsp_o
);
    logic [1:0] wait_r;
    // Missing registers are already folded into the count that the bench hands in.
    always_ff @(posedge sys_clk_i or posedge rst_i)
        if (rst_i)
            {wait_r, done_o} <= 3'h0;
        else
        begin
            done_o <= wait_r == 2'h1;
            wait_r <= req_i ? 2'h3 : wait_r - {1'b0, wait_r != 2'h0};
        end
    // The answer is garbage outside the done pulse, so a late sample shows.
    assign rsp_o = done_o ? rsp_i : ~rsp_i;
endmodule // mbal_engine_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the query handler.
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0]  fn;
        logic [7:0]  code;
        logic [15:0] qc;
        logic [15:0] ok;
        logic [15:0] st;
        logic [7:0]  exc;
    } mbal_row_s;
    localparam logic [7:0] ME = 8'h19;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] rx_data_i = 8'h00;
    logic       rx_valid_i = 1'b0;
    logic       rx_err_i = 1'b0;
    logic       rx_end_i = 1'b0;
    logic       tx_ready_i = 1'b0;
    logic       svc_req_o, svc_done_i, norm_go_o, tx_valid_o, tx_last_o;
    logic [7:0] tx_data_o;
    mbal_pkg::mbal_svc_req_s svc_o;
    mbal_pkg::mbal_svc_rsp_s svc_rsp_i;
    mbal_pkg::mbal_svc_rsp_s m_rsp = '0;
    mbal_pkg::mbal_log_s     log_o;
    int bad_count = 0;
    int comparisons = 0;
    int n_tx = 0;
    int n_req = 0;
    mbal_row_s rows[7] = '{'{8'h03, 8'h00, 16'h0002, 16'h0002, 16'h03EE, 8'h00},
        '{8'h10, 8'h02, 16'h0003, 16'h0001, 16'h0010, 8'h00}, '{8'h03, 8'h02, 16'h0002, 16'h0000, 16'h0000, 8'h02},
        '{8'h10, 8'h00, 16'h0000, 16'h0005, 16'h0001, 8'h02}, '{8'h10, 8'h01, 16'h0001, 16'h0000, 16'h0000, 8'h01},
        '{8'h03, 8'h03, 16'h0001, 16'h0000, 16'h0000, 8'h03}, '{8'h2B, 8'h01, 16'h0001, 16'h0000, 16'h0000, 8'h01}};
    mbal_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1), .own_addr_i(ME), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .rx_err_i(rx_err_i), .rx_end_i(rx_end_i), .svc_req_o(svc_req_o), .svc_o(svc_o),
        .svc_done_i(svc_done_i), .svc_rsp_i(svc_rsp_i), .norm_go_o(norm_go_o), .log_o(log_o),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));
    mbal_engine_model u_eng (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(svc_req_o), .rsp_i(m_rsp),
        .done_o(svc_done_i), .rsp_o(svc_rsp_i));
    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        if (tx_valid_o === 1'b1 || norm_go_o === 1'b1) n_tx <= n_tx + 1;
        if (svc_req_o === 1'b1) n_req <= n_req + 1;
    end
    function automatic logic [15:0] crc(logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i])
        begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic chk(bit ok, string m);
        comparisons++;
        if (!ok)
        begin
            bad_count++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic send(logic [7:0] q[$], bit bad, bit err);
        logic [15:0] c;
        c = crc(q) ^ {bad, 15'h0000};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i])
        begin
            @(posedge sys_clk_i);
            {rx_data_i, rx_valid_i, rx_err_i} <= {q[i], 2'h2};
            @(posedge sys_clk_i);
            {rx_data_i, rx_valid_i, rx_err_i} <= {~q[i], 1'b0, err};
        end
        rx_end_i <= 1'b1;
        @(posedge sys_clk_i);
        {rx_end_i, rx_err_i} <= 2'h0;
    endtask
    // The sink stalls every other cycle, so each reply byte except the first of an error reply must wait once.
    task automatic get(logic [7:0] e[$], string m);
        logic [7:0]  g[$];
        logic [15:0] c;
        c = crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        repeat (100)
        begin
            @(posedge sys_clk_i);
            if (tx_valid_o === 1'b1 && tx_ready_i) g.push_back(tx_data_o);
            if (tx_valid_o === 1'b1 && tx_ready_i && tx_last_o === 1'b1) break;
            tx_ready_i <= ~tx_ready_i;
        end
        tx_ready_i <= 1'b0;
        @(posedge sys_clk_i);
        chk(g == e, m);
        $display("test %s done", m);
    endtask
    task automatic settle(int t0, int r0, int dt, int dr, string m);
        repeat (20) @(posedge sys_clk_i);
        chk(n_tx - t0 == dt && n_req - r0 == dr, m);
        $display("test %s done", m);
    endtask
    task automatic run_row(mbal_row_s r);
        int t0 = n_tx;
        int r0 = n_req;
        bit ok;
        ok = r.exc == 8'h00 && (r.fn == 8'h03 || r.fn == 8'h10);
        if (!ok) r.st = 16'h0000;
        m_rsp <= {r.code, r.ok, r.st};
        send({ME, r.fn, r.st[15:8], r.st[7:0], r.qc[15:8], r.qc[7:0]}, 0, 0);
        if (r.exc != 8'h00)
            get({ME, r.fn + 8'h80, r.exc}, "error reply");
        else
            settle(t0, r0, 1, 1, "normal go");
        if (!ok) r.ok = 16'h0000;
        send({ME, 8'h46}, 0, 0);
        get({ME, 8'h46, r.st[15:8], r.st[7:0], r.ok[15:8], r.ok[7:0]}, "log reply");
    endtask
    task automatic quiet(logic [7:0] q[$], bit bad, bit err, int dr, string m);
        int t0 = n_tx;
        int r0 = n_req;
        send(q, bad, err);
        settle(t0, r0, 0, dr, m);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk(tx_valid_o === 1'b0 && svc_req_o === 1'b0 && log_o === '0, "reset values");
        foreach (rows[i]) run_row(rows[i]);
        m_rsp <= {8'h01, 32'h0000_0000};
        quiet({8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0, 1, "broadcast");
        quiet({8'h00, 8'h46}, 0, 0, 0, "log broadcast");
        quiet({ME}, 0, 0, 0, "short frame");
        quiet({ME, 8'h46}, 1, 0, 0, "bad crc");
        quiet({ME, 8'h46}, 0, 1, 0, "line error");
        run_row(rows[0]);
        send({ME, 8'h03, 8'h03, 8'hEE, 8'h00, 8'h02}, 0, 0);
        repeat (10) @(posedge sys_clk_i);
        chk(log_o === {16'h03EE, 16'h0002}, "log filled");
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk(log_o === '0 && tx_valid_o === 1'b0 && norm_go_o === 1'b0, "mid reset");
        send({ME, 8'h46}, 0, 0);
        get({ME, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00}, "log after reset");
        tally_and_finish();
    end
    initial
    begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule // tb_top
